// >>> hw/acd_pkg.sv
// Constants for the audio clock divider configuration block.
// Assumes 32-bit APB access, one 8-bit register per aligned word.
package acd_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_MOD = 8'h3b;
  localparam logic [7:0] IDX_PRI = 8'h3c;
  localparam logic [7:0] IDX_SEC = 8'h3d;
  localparam logic [7:0] IDX_ANA = 8'h3e;
  localparam logic [7:0] IDX_EN = 8'h44;
  localparam logic [7:0] IDX_CTL = 8'h60;
  localparam logic [7:0] IDX_STAT = 8'h61;
  localparam logic [ADDR_W-1:0] A_MOD = {2'h0, IDX_MOD, 2'h0};
  localparam logic [ADDR_W-1:0] A_PRI = {2'h0, IDX_PRI, 2'h0};
  localparam logic [ADDR_W-1:0] A_SEC = {2'h0, IDX_SEC, 2'h0};
  localparam logic [ADDR_W-1:0] A_ANA = {2'h0, IDX_ANA, 2'h0};
  localparam logic [ADDR_W-1:0] A_EN = {2'h0, IDX_EN, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTL = {2'h0, IDX_CTL, 2'h0};
  localparam logic [ADDR_W-1:0] A_STAT = {2'h0, IDX_STAT, 2'h0};

  // ==========================================================================
  // Field positions, write masks and reset values
  // ==========================================================================
  localparam int MOD_DIV_LSB = 4;
  localparam int MOD_DBL_BIT = 3;
  localparam int PRI_HI_BIT = 2;
  localparam int SEC_HI_BIT = 1;
  localparam int EN_N_BIT = 2;
  localparam int EN_M_BIT = 1;
  localparam int EN_PDM_BIT = 0;
  localparam int CTL_AUTO_BIT = 0;
  localparam logic [7:0] MOD_WMASK = 8'h3e;
  localparam logic [7:0] ANA_WMASK = 8'h3f;
  localparam logic [7:0] EN_WMASK = 8'h07;
  localparam logic [7:0] CTL_WMASK = 8'h01;
  localparam logic [7:0] RST_MOD = 8'h00;
  localparam logic [7:0] RST_LOW = 8'h01;
  localparam logic [7:0] RST_ANA = 8'h01;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;

  // ==========================================================================
  // Divider slots and ratio coding
  // ==========================================================================
  localparam int RATIO_W = 10;
  localparam int NDIV = 7;
  localparam int D_DAC = 0;
  localparam int D_PRI = 1;
  localparam int D_SEC = 2;
  localparam int D_NM = 3;
  localparam int D_N = 4;
  localparam int D_M = 5;
  localparam int D_PDM = 6;
  localparam logic [RATIO_W-1:0] BCLK_ZERO_RATIO = 10'h200;
  localparam logic [RATIO_W-1:0] NM_ZERO_RATIO = 10'h040;
  localparam int APB_WAIT_CYCLES = 0;

  // Bit-clock code: zero means the longest ratio
  function automatic logic [RATIO_W-1:0] bclk_ratio(input logic [8:0] code);
    return (code == 9'h000) ? BCLK_ZERO_RATIO : {1'b0, code};
  endfunction : bclk_ratio

  // Analog ratio code: zero means 64
  function automatic logic [RATIO_W-1:0] nm_ratio(input logic [5:0] code);
    return (code == 6'h00) ? NM_ZERO_RATIO : {4'h0, code};
  endfunction : nm_ratio

  // Modulator code 1/2/4; reserved code falls back to 1; doubling off halves rate
  function automatic logic [RATIO_W-1:0] dac_ratio(input logic [1:0] code,
                                                   input logic dbl_off);
    logic [RATIO_W-1:0] base;
    base = (code == 2'h1) ? 10'h002 : (code == 2'h2) ? 10'h004 : 10'h001;
    return dbl_off ? {base[RATIO_W-2:0], 1'b0} : base;
  endfunction : dac_ratio

endpackage : acd_pkg

// >>> hw/acd_div.sv
// One programmable clock divider counting source ticks.
// Assumes src_tick and enable come from logic on pclk.
`timescale 1ns/10ps
module acd_div
  import acd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic src_tick,
  input wire logic enable,
  input wire logic [acd_pkg::RATIO_W-1:0] ratio,
  output logic div_tick,
  output logic div_level
);

  import acd_pkg::*;

  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic tick;
    logic level;
  } acd_div_state_t;

  acd_div_state_t q;
  acd_div_state_t d;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Disabled divider is parked at zero so it restarts from a clean phase
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (!enable)
    begin
      d = '0;
    end
    else if (src_tick)
    begin
      if (q.cnt >= ratio - 10'h001)
      begin
        d.cnt = '0;
        d.tick = 1'b1;
        d.level = ~q.level;
      end
      else
      begin
        d.cnt = q.cnt + 10'h001;
      end
    end
  end

  // Clock enable freezes every bit of state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign div_tick = q.tick;
  assign div_level = q.level;

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_DIV_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !enable) |=> (!div_tick && !div_level && q.cnt == '0))
    else $error("disabled divider still moving");

  AST_DIV_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && enable && src_tick && ratio == 10'h001) |=> div_tick)
    else $error("divide-by-one missed a tick");

endmodule : acd_div

// >>> hw/acd_top.sv
// Clock divider configuration registers with their divider bank.
// Assumes an APB master on pclk and a source tick and auto ratios on pclk.
//
// Functional notes
// - DAC modulator code 0,1,2 divides by 1,2,4; code 3 reserved.
// - Auto detection replaces programmed modulator, bit-clock and analog ratios.
// - Doubling bit 0 keeps 2x modulator clock; 1 disables it.
// - Bit 2 is the top bit of the primary bit-clock divider.
// - Bit 1 is the top bit of the secondary bit-clock divider.
// - Bit-clock code 0 divides by 512, others by their value.
// - Analog ratio code 0 divides by 64, 1 to 63 by the code.
// - Enable bits 2,1,0 run the N, M and PDM dividers.
// - Low fields and analog ratio reset to 1; others reset to 0.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module acd_top
  import acd_pkg::*;
#(
  parameter logic [acd_pkg::RATIO_W-1:0] N_RATIO = 10'h001,
  parameter logic [acd_pkg::RATIO_W-1:0] M_RATIO = 10'h001,
  parameter logic [acd_pkg::RATIO_W-1:0] PDM_RATIO = 10'h001
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic src_tick,
  input wire logic [acd_pkg::RATIO_W-1:0] auto_dac_ratio,
  input wire logic [acd_pkg::RATIO_W-1:0] auto_pri_ratio,
  input wire logic [acd_pkg::RATIO_W-1:0] auto_sec_ratio,
  input wire logic [acd_pkg::RATIO_W-1:0] auto_nm_ratio,
  output logic [acd_pkg::NDIV-1:0] div_tick,
  output logic [acd_pkg::NDIV-1:0] div_level
);

  import acd_pkg::*;

  typedef struct packed {
    logic [7:0] mod;
    logic [7:0] pri_low;
    logic [7:0] sec_low;
    logic [7:0] ana;
    logic [7:0] en;
    logic [7:0] ctl;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } acd_regs_t;

  acd_regs_t q;
  acd_regs_t d;
  logic [RATIO_W-1:0] ratio [NDIV];
  logic [NDIV-1:0] div_en;
  logic setup;
  logic access;
  logic auto_on;
  logic [7:0] rd_byte;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Shared by the error answer and the error checks
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == A_MOD) || (a == A_PRI) || (a == A_SEC) || (a == A_ANA) ||
           (a == A_EN) || (a == A_CTL) || (a == A_STAT);
  endfunction : addr_hit

  assign setup = psel && !penable;
  assign access = psel && penable && q.ready;
  assign auto_on = q.ctl[CTL_AUTO_BIT];

  // Read mux; reserved bits are zero in storage so they read as zero
  always_comb
  begin
    case (paddr)
      A_MOD: rd_byte = q.mod;
      A_PRI: rd_byte = q.pri_low;
      A_SEC: rd_byte = q.sec_low;
      A_ANA: rd_byte = q.ana;
      A_EN: rd_byte = q.en;
      A_CTL: rd_byte = q.ctl;
      A_STAT: rd_byte = {div_level[D_PDM:D_DAC], auto_on};
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // APB slave and register file
  // ==========================================================================
  // Ready is raised in the setup cycle so the access phase ends at once;
  // read data is captured in setup, while the address is already stable.
  always_comb
  begin
    d = q;
    d.ready = 1'b0;
    d.err = 1'b0;
    if (setup)
    begin
      d.ready = 1'b1;
      d.err = !addr_hit(paddr);
      d.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    // Write lands only at the edge that completes the access phase
    if (access && pwrite && pstrb[0])
    begin
      case (paddr)
        A_MOD: d.mod = pwdata[7:0] & MOD_WMASK;
        A_PRI: d.pri_low = pwdata[7:0];
        A_SEC: d.sec_low = pwdata[7:0];
        A_ANA: d.ana = pwdata[7:0] & ANA_WMASK;
        A_EN: d.en = pwdata[7:0] & EN_WMASK;
        A_CTL: d.ctl = pwdata[7:0] & CTL_WMASK;
        default: d.mod = q.mod;
      endcase
    end
  end

  // State register; a low ce also stalls the bus, by design
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.mod <= RST_MOD;
      q.pri_low <= RST_LOW;
      q.sec_low <= RST_LOW;
      q.ana <= RST_ANA;
      q.en <= RST_EN;
      q.ctl <= RST_CTL;
      q.rdata <= 32'h0000_0000;
      q.ready <= 1'b0;
      q.err <= 1'b0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;

  // ==========================================================================
  // Effective ratios
  // ==========================================================================
  // Auto mode overrides only the fields it detects; M, N and PDM stay fixed
  always_comb
  begin
    if (auto_on)
    begin
      ratio[D_DAC] = auto_dac_ratio;
      ratio[D_PRI] = auto_pri_ratio;
      ratio[D_SEC] = auto_sec_ratio;
      ratio[D_NM] = auto_nm_ratio;
    end
    else
    begin
      ratio[D_DAC] = dac_ratio(q.mod[MOD_DIV_LSB+1:MOD_DIV_LSB], q.mod[MOD_DBL_BIT]);
      ratio[D_PRI] = bclk_ratio({q.mod[PRI_HI_BIT], q.pri_low});
      ratio[D_SEC] = bclk_ratio({q.mod[SEC_HI_BIT], q.sec_low});
      ratio[D_NM] = nm_ratio(q.ana[5:0]);
    end
    ratio[D_N] = N_RATIO;
    ratio[D_M] = M_RATIO;
    ratio[D_PDM] = PDM_RATIO;
  end

  // Enables of the first four live in another register; they free-run here
  always_comb
  begin
    div_en = '1;
    div_en[D_N] = q.en[EN_N_BIT];
    div_en[D_M] = q.en[EN_M_BIT];
    div_en[D_PDM] = q.en[EN_PDM_BIT];
  end

  // ==========================================================================
  // Divider bank
  // ==========================================================================
  for (genvar i = 0; i < NDIV; i++)
  begin : g_div
    acd_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .src_tick(src_tick),
      .enable(div_en[i]),
      .ratio(ratio[i]),
      .div_tick(div_tick[i]),
      .div_level(div_level[i])
    );
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_wr_mod;
    psel && penable && pready && pwrite && pstrb[0] && paddr == A_MOD && ce;
  endsequence

  sequence s_rd_mod;
    psel && penable && pready && !pwrite && paddr == A_MOD;
  endsequence

  AST_DAC_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_mod ##0 (pwdata[5:4] == 2'h2 && !pwdata[3] && !auto_on))
    |=> (!auto_on |-> ratio[D_DAC] == 10'h004))
    else $error("modulator code 2 not divide by 4");

  AST_AUTO_OVR: assert property (@(posedge pclk) disable iff (!presetn)
    auto_on |-> (ratio[D_PRI] == auto_pri_ratio && ratio[D_NM] == auto_nm_ratio
                 && ratio[D_DAC] == auto_dac_ratio && ratio[D_SEC] == auto_sec_ratio))
    else $error("auto detection did not override ratios");

  AST_DOUBLE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[5:4] == 2'h1 && q.mod[3]) |-> ratio[D_DAC] == 10'h004)
    else $error("doubling off did not halve modulator rate");

  AST_PRI_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[2]) |-> ratio[D_PRI] == {2'h1, q.pri_low})
    else $error("primary top bit not applied");

  AST_SEC_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[1]) |-> ratio[D_SEC] == {2'h1, q.sec_low})
    else $error("secondary top bit not applied");

  AST_BCLK_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && !q.mod[2] && q.pri_low == 8'h00) |-> ratio[D_PRI] == 10'h200)
    else $error("bit-clock code zero not 512");

  AST_NM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.ana[5:0] == 6'h00) |-> ratio[D_NM] == 10'h040)
    else $error("analog code zero not 64");

  AST_EN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (!q.en[2] && ce)[*2] |-> (!div_tick[D_N] && !div_level[D_N]))
    else $error("N divider runs while disabled");

  AST_RSVD_RD: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_mod |-> (prdata[7:6] == 2'h0 && !prdata[0] && prdata[31:8] == 24'h0))
    else $error("reserved bits read nonzero");

  AST_RESET_VAL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (q.pri_low == 8'h01 && q.sec_low == 8'h01 &&
                        q.ana == 8'h01 && q.mod == 8'h00 && q.en == 8'h00))
    else $error("reset values wrong");

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && ce) |=> pready ##1 (!ce || !pready))
    else $error("slave answer not one access cycle");

  // ==========================================================================
  // Storage, masks, ratio decode and error answer
  // ==========================================================================
  // Any completed write with its byte lane on
  sequence s_wr_done;
    psel && penable && pready && pwrite && pstrb[0] && ce;
  endsequence

  // Any completed access, read or write
  sequence s_acc_done;
    psel && penable && pready;
  endsequence

  sequence s_wr_pri;
    s_wr_done ##0 (paddr == A_PRI);
  endsequence

  sequence s_wr_sec;
    s_wr_done ##0 (paddr == A_SEC);
  endsequence

  // Low bytes keep the full written value, no mask
  AST_PRI_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_pri |=> q.pri_low == $past(pwdata[7:0]))
    else $error("primary low byte not stored");

  AST_SEC_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_sec |=> q.sec_low == $past(pwdata[7:0]))
    else $error("secondary low byte not stored");

  // Reserved storage never holds a one, whatever software writes
  AST_MOD_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    q.mod[7:6] == 2'h0 && !q.mod[0])
    else $error("modulator reserved bits set");

  AST_ANA_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    q.ana[7:6] == 2'h0)
    else $error("analog ratio reserved bits set");

  AST_EN_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    q.en[7:3] == 5'h00)
    else $error("enable reserved bits set");

  // Modulator codes 0 and 1 without the doubling bit, code 2 with it
  AST_DAC_CODE0: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[5:4] == 2'h0 && !q.mod[3]) |-> ratio[D_DAC] == 10'h001)
    else $error("modulator code 0 not divide by 1");

  AST_DAC_CODE1: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[5:4] == 2'h1 && !q.mod[3]) |-> ratio[D_DAC] == 10'h002)
    else $error("modulator code 1 not divide by 2");

  AST_DOUBLE_CODE2: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.mod[5:4] == 2'h2 && q.mod[3]) |-> ratio[D_DAC] == 10'h008)
    else $error("doubling off did not halve code 2 rate");

  // Plain codes pass straight through as the ratio; secondary code zero gives 512
  AST_PRI_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && !q.mod[2] && q.pri_low != 8'h00) |-> ratio[D_PRI] == {2'h0, q.pri_low})
    else $error("primary plain code not passed through");

  AST_SEC_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && !q.mod[1] && q.sec_low == 8'h00) |-> ratio[D_SEC] == 10'h200)
    else $error("secondary code zero not 512");

  AST_NM_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_on && q.ana[5:0] != 6'h00) |-> ratio[D_NM] == {4'h0, q.ana[5:0]})
    else $error("analog plain code not passed through");

  // Same gate as the N check, for the other two switchable dividers
  AST_EN_M_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (!q.en[1] && ce)[*2] |-> (!div_tick[D_M] && !div_level[D_M]))
    else $error("M divider runs while disabled");

  AST_EN_PDM_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (!q.en[0] && ce)[*2] |-> (!div_tick[D_PDM] && !div_level[D_PDM]))
    else $error("PDM divider runs while disabled");

  // Unmapped address answers with an error and zero data; mapped ones never err
  AST_ERR_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (s_acc_done ##0 !addr_hit(paddr)) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access answered wrongly");

  AST_ERR_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (s_acc_done ##0 addr_hit(paddr)) |-> !pslverr)
    else $error("mapped access flagged an error");

endmodule : acd_top

// >>> bench/test_audio_clock_divider_config.sv
// Self-checking bench for the clock divider configuration block.
// Assumes acd_pkg and acd_top are compiled first; bench acts as APB master.
`timescale 1ns/10ps
module test_audio_clock_divider_config;
  import acd_pkg::*;

  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  localparam logic [RATIO_W-1:0] N_R = 10'h003;
  localparam logic [RATIO_W-1:0] M_R = 10'h002;
  localparam logic [RATIO_W-1:0] P_R = 10'h005;
  localparam int CEIL = 60000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic src_tick = 1'b1;
  logic [RATIO_W-1:0] a_dac = 10'h006;
  logic [RATIO_W-1:0] a_pri = 10'h007;
  logic [RATIO_W-1:0] a_sec = 10'h009;
  logic [RATIO_W-1:0] a_nm = 10'h005;
  logic [NDIV-1:0] div_tick;
  logic [NDIV-1:0] div_level;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  acd_top #(.N_RATIO(N_R), .M_RATIO(M_R), .PDM_RATIO(P_R)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_tick(src_tick),
    .auto_dac_ratio(a_dac), .auto_pri_ratio(a_pri), .auto_sec_ratio(a_sec),
    .auto_nm_ratio(a_nm), .div_tick(div_tick), .div_level(div_level));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  // Hang guard: a stuck handshake still reaches the report
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; an idle edge first so strobes never change twice at once
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", t, APB_WAIT_CYCLES + 1);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(what, r, {24'h0, exp});
  endtask : rd_chk

  // Edges between the second and third output pulse: one full settled period
  task automatic period(input int idx, output int p);
    int n;
    int seen;
    logic lv;
    n = 0;
    seen = 0;
    p = 0;
    lv = 1'b0;
    while (seen < 3 && n < 2000)
    begin
      @(posedge pclk);
      n++;
      if (seen == 2)
        p++;
      if (div_tick[idx] === 1'b1)
      begin
        seen++;
        if (seen == 2)
          lv = div_level[idx];
      end
    end
    // Level must flip with every output tick
    chk("level toggle", {31'h0, div_level[idx] ^ lv}, 32'h1);
  endtask : period

  // Disabled dividers must stay silent and low
  task automatic quiet(input logic [2:0] mask);
    int c;
    c = 0;
    // First edge may still show the last tick launched while enabled
    @(posedge pclk);
    repeat (40)
    begin
      @(posedge pclk);
      if ((div_tick[6:4] & mask) !== 3'h0)
        c++;
    end
    chk("idle ticks", c, 0);
    chk("idle level", {29'h0, div_level[6:4] & mask}, 32'h0);
  endtask : quiet

  function automatic int bc(input logic [8:0] c);
    return (c == 9'h000) ? 512 : int'(c);
  endfunction : bc

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd_chk("mod rst", A_MOD, 8'h00);
    rd_chk("pri rst", A_PRI, 8'h01);
    rd_chk("sec rst", A_SEC, 8'h01);
    rd_chk("ana rst", A_ANA, 8'h01);
    rd_chk("en rst", A_EN, 8'h00);
    rd_chk("ctl rst", A_CTL, 8'h00);
  endtask : t_reset

  task automatic t_reserved();
    logic [31:0] r;
    logic e;
    wr(A_MOD, 8'hff);
    wr(A_ANA, 8'hff);
    wr(A_EN, 8'hff);
    rd_chk("mod mask", A_MOD, 8'h3e);
    rd_chk("ana mask", A_ANA, 8'h3f);
    rd_chk("en mask", A_EN, 8'h07);
    // Byte lane off: the write is ignored
    pstrb <= 4'h0;
    wr(A_PRI, 8'h55);
    pstrb <= 4'hf;
    rd_chk("strobe off", A_PRI, 8'h01);
    apb(1'b0, 12'h100, 8'h00, r, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask : t_reserved

  task automatic t_dac();
    int p;
    for (int c = 0; c < 4; c++)
      for (int d = 0; d < 2; d++)
      begin
        wr(A_MOD, {2'b00, c[1:0], d[0], 3'b000});
        period(0, p);
        chk("dac period", p, ((c == 1) ? 2 : (c == 2) ? 4 : 1) << d);
      end
  endtask : t_dac

  task automatic t_bclk();
    logic [8:0] codes [5] = '{9'h000, 9'h001, 9'h002, 9'h1ff, 9'h100};
    logic [8:0] s;
    int p;
    foreach (codes[i])
    begin
      s = {~codes[i][8], codes[i][7:0]};
      wr(A_MOD, {5'b0, codes[i][8], s[8], 1'b0});
      wr(A_PRI, codes[i][7:0]);
      wr(A_SEC, s[7:0]);
      period(1, p);
      chk("pri period", p, bc(codes[i]));
      period(2, p);
      chk("sec period", p, bc(s));
    end
  endtask : t_bclk

  task automatic t_ana();
    logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h3f, 6'h02};
    int p;
    foreach (codes[i])
    begin
      wr(A_ANA, {2'b00, codes[i]});
      period(3, p);
      chk("ana period", p, (codes[i] == 6'h00) ? 64 : int'(codes[i]));
    end
  endtask : t_ana

  task automatic t_enable();
    int rat [3] = '{int'(P_R), int'(M_R), int'(N_R)};
    int p;
    wr(A_EN, 8'h00);
    quiet(3'b111);
    for (int b = 0; b < 3; b++)
    begin
      wr(A_EN, 8'h01 << b);
      period(6 - b, p);
      chk("enabled period", p, rat[b]);
      quiet(~(3'b001 << (2 - b)));
    end
  endtask : t_enable

  task automatic t_auto();
    int p;
    int exp [4] = '{6, 7, 9, 5};
    wr(A_MOD, 8'h26);
    wr(A_ANA, 8'h02);
    wr(A_CTL, 8'h01);
    rd_chk("ctl on", A_CTL, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      period(i, p);
      chk("auto period", p, exp[i]);
    end
    wr(A_CTL, 8'h00);
    period(3, p);
    chk("manual period", p, 2);
  endtask : t_auto

  // Low clock enable with the bus idle: dividers hold still
  task automatic t_hold();
    logic [NDIV-1:0] lv;
    @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    lv = div_level;
    repeat (10) @(posedge pclk);
    chk("frozen level", {25'h0, div_level}, {25'h0, lv});
    ce <= 1'b1;
  endtask : t_hold

  // Reset in mid-run brings written registers back to their reset values
  task automatic t_rerun();
    wr(A_PRI, 8'h33);
    wr(A_CTL, 8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("pri rerun", A_PRI, 8'h01);
    rd_chk("ctl rerun", A_CTL, 8'h00);
  endtask : t_rerun

  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_reserved();
    t_dac();
    t_bclk();
    t_ana();
    t_enable();
    t_auto();
    t_hold();
    t_rerun();
    end_of_test();
  end

endmodule : test_audio_clock_divider_config
